/* File: mpwm_pkg.sv */
// shared constants and types for the motor pwm pin-control block
package mpwm_pkg;
    // clock
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;

    // dead time limits; least rounds up, longest rounds down
    localparam int DT_SA_MIN_NS   = 500;
    localparam int DT_SA_MAX_NS   = 6000;
    localparam int DT_HOST_MAX_PS = 31875000;
    localparam logic [11:0] DT_SA_MIN_CYC =
        12'((DT_SA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] DT_SA_MAX_CYC   = 12'(DT_SA_MAX_NS / CLK_PERIOD_NS);
    localparam logic [11:0] DT_HOST_MAX_CYC = 12'(DT_HOST_MAX_PS / (CLK_PERIOD_NS * 1000));

    // retry interval, counted in millisecond ticks
    localparam int RETRY_W = 24;
    localparam int RETRY_SA_MAX_S     = 53;
    localparam int RETRY_HOST_MAX_MIN = 273;
    localparam logic [23:0] RETRY_SA_MAX_MS   = 24'(RETRY_SA_MAX_S * 1000);
    localparam logic [23:0] RETRY_HOST_MAX_MS = 24'(RETRY_HOST_MAX_MIN * 60000);
    localparam int MS_NS      = 1_000_000;
    localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;

    // spacing of the two strap sampling moments after init
    localparam int STRAP_GAP_NS = 10_000;
    localparam logic [11:0] STRAP_GAP_CYC = 12'(STRAP_GAP_NS / CLK_PERIOD_NS);

    // serial link
    localparam int UART_BAUD_MIN     = 9504;
    localparam int UART_BAUD_MAX     = 9696;
    localparam int UART_BAUD_NOM     = 9600;
    localparam int UART_BIT_CYC_DEF  = CLK_HZ / UART_BAUD_NOM;

    // controller states
    typedef enum logic [4:0] {
        ST_INIT   = 5'h01,
        ST_STRAP  = 5'h02,
        ST_RUN    = 5'h04,
        ST_FAULT  = 5'h08,
        ST_RETRY  = 5'h10
    } mpwm_state_e;

    // receiver states
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } mpwm_rx_e;

    // gate demands or drives, index 0 = U, 1 = V, 2 = W
    typedef struct packed {
        logic [2:0] top;
        logic [2:0] bot;
    } mpwm_gate_s;
endpackage

/* File: mpwm_uart_rx.sv */
// serial receiver for host commands on the dual-use strobe pin
module mpwm_uart_rx #(
    parameter int BIT_CYC = mpwm_pkg::UART_BIT_CYC_DEF
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // control
    input  wire logic       enable,
    // pin
    input  wire logic       rx_pin,
    // received byte
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_frame_err
);
    import mpwm_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF_BIT = 16'(BIT_CYC / 2);

    typedef struct packed {
        logic [1:0]  sync;
        mpwm_rx_e    st;
        logic [15:0] cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic        valid;
        logic        ferr;
    } mpwm_rx_s;

    mpwm_rx_s s_reg;
    mpwm_rx_s s_next;

    // 8 data bits, lsb first, one stop bit; sampled mid-bit
    always_comb begin
        s_next       = s_reg;
        s_next.sync  = {s_reg.sync[0], rx_pin};
        s_next.valid = 1'b0;
        s_next.cnt   = s_reg.cnt + 16'h0001;
        case (s_reg.st)
            RX_IDLE: begin
                s_next.cnt = 16'h0000;
                if (!s_reg.sync[1]) begin
                    s_next.st = RX_START;
                end
            end
            RX_START: begin
                if (s_reg.cnt == HALF_BIT) begin
                    s_next.cnt = 16'h0000;
                    s_next.st  = s_reg.sync[1] ? RX_IDLE : RX_DATA; // glitch rejects
                end
            end
            RX_DATA: begin
                if (s_reg.cnt == BIT_LAST) begin
                    s_next.cnt     = 16'h0000;
                    s_next.shift   = {s_reg.sync[1], s_reg.shift[7:1]};
                    s_next.bit_idx = s_reg.bit_idx + 3'h1;
                    if (s_reg.bit_idx == 3'h7) begin
                        s_next.st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (s_reg.cnt == BIT_LAST) begin
                    s_next.st    = RX_IDLE;
                    s_next.data  = s_reg.shift;
                    s_next.valid = 1'b1;
                    s_next.ferr  = !s_reg.sync[1];
                end
            end
            default: s_next.st = RX_IDLE;
        endcase
        // in standalone mode the pin is ours to drive, so ignore it
        if (!enable) begin
            s_next.st      = RX_IDLE;
            s_next.bit_idx = 3'h0;
            s_next.valid   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg      <= '0;
            s_reg.sync <= 2'h3;
            s_reg.st   <= RX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rx_data      = s_reg.data;
    assign rx_valid     = s_reg.valid;
    assign rx_frame_err = s_reg.ferr;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_rx_gated: assert property (!enable |=> !rx_valid)
        else $error("byte received while link disabled");
    a_bit_period: assert property (
        (s_reg.st == RX_DATA && s_reg.cnt == 16'h0000) |-> s_reg.st == RX_DATA [*8])
        else $error("data bit shorter than expected");
endmodule

/* File: mpwm_pin_ctrl.sv */
// pin-level control of the three-phase pwm outputs, fault, straps and strobes
module mpwm_pin_ctrl #(
    parameter int MS_CYC  = mpwm_pkg::MS_CYC_DEF,
    parameter int BIT_CYC = mpwm_pkg::UART_BIT_CYC_DEF
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // two-way reset pin
    input  wire logic                reset_pin_in,
    output logic                     reset_pin_out,
    output logic                     reset_pin_oe_n,
    // internal reset sources
    input  wire logic                clock_loss,
    input  wire logic                supply_low,
    // straps and fault
    input  wire logic                fault_input,
    input  wire logic                polarity_base_rate_strap,
    input  wire logic                boost_strobe_mode_strap,
    output logic                     boost_strobe_out,
    output logic                     boost_strobe_oe_n,
    // dual-use rate strobe / serial pin
    input  wire logic                carrier_rate_strobe_serial_in,
    output logic                     carrier_rate_strobe_out,
    output logic                     carrier_rate_strobe_oe_n,
    // settings from the control core
    input  wire mpwm_pkg::mpwm_gate_s gate_demand,
    input  wire logic [11:0]         dead_time_cycles,
    input  wire logic [23:0]         retry_ms,
    input  wire logic                mux_rate_read,
    input  wire logic                mux_boost_read,
    // gate drives
    output logic                     phase_u_high_drive,
    output logic                     phase_u_low_drive,
    output logic                     phase_v_high_drive,
    output logic                     phase_v_low_drive,
    output logic                     phase_w_high_drive,
    output logic                     phase_w_low_drive,
    output logic                     pwm_oe_n,
    // status
    output logic                     standalone_mode,
    output logic                     pwm_active_low,
    output logic                     base_rate_60hz,
    output logic                     fault_active,
    // host serial data
    output logic [7:0]               rx_data,
    output logic                     rx_valid,
    output logic                     rx_frame_err
);
    import mpwm_pkg::*;

    localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);

    typedef struct packed {
        logic [1:0]       rp_sync;
        logic [1:0]       flt_sync;
        logic [1:0]       cl_sync;
        logic [1:0]       sl_sync;
        logic [1:0]       pol_sync;
        logic [1:0]       mode_sync;
        mpwm_state_e      st;
        logic [11:0]      wait_cnt;
        logic [16:0]      ms_cnt;
        logic [23:0]      retry_cnt;
        logic             standalone;
        logic             active_low;
        logic             rate_60;
        logic [2:0]       cur_top;
        logic [2:0]       cur_bot;
        logic [2:0][11:0] dt_cnt;
        mpwm_gate_s       drive;
        logic             drv_oe_n;
        logic             rst_drv;
        logic             rate_oe_n;
        logic             boost_oe_n;
    } mpwm_core_s;

    mpwm_core_s s_reg;
    mpwm_core_s s_next;

    logic [11:0] dt_eff;
    logic [23:0] retry_eff;
    logic        ms_tick;
    logic        fault_s;
    logic        want_top;
    logic        want_bot;

    // clamp helper, used for both dead time and retry limits
    function automatic logic [23:0] clamp24(input logic [23:0] v, input logic [23:0] lo,
                                            input logic [23:0] hi);
        logic [23:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end
        if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // settings clamped to the limits of the mode in force
    always_comb begin
        if (s_reg.standalone) begin
            dt_eff    = 12'(clamp24({12'h000, dead_time_cycles}, {12'h000, DT_SA_MIN_CYC},
                                    {12'h000, DT_SA_MAX_CYC}));
            retry_eff = clamp24(retry_ms, 24'h000000, RETRY_SA_MAX_MS);
        end else begin
            dt_eff    = 12'(clamp24({12'h000, dead_time_cycles}, 24'h000000,
                                    {12'h000, DT_HOST_MAX_CYC}));
            retry_eff = clamp24(retry_ms, 24'h000000, RETRY_HOST_MAX_MS);
        end
    end

    assign fault_s = s_reg.flt_sync[1];
    assign ms_tick = (s_reg.ms_cnt == MS_LAST);

    // next state: synchronisers, sequencing, dead time and pin drives
    always_comb begin
        s_next           = s_reg;
        want_top         = 1'b0;
        want_bot         = 1'b0;
        s_next.rp_sync   = {s_reg.rp_sync[0], reset_pin_in};
        s_next.flt_sync  = {s_reg.flt_sync[0], fault_input};
        s_next.cl_sync   = {s_reg.cl_sync[0], clock_loss};
        s_next.sl_sync   = {s_reg.sl_sync[0], supply_low};
        s_next.pol_sync  = {s_reg.pol_sync[0], polarity_base_rate_strap};
        s_next.mode_sync = {s_reg.mode_sync[0], boost_strobe_mode_strap};
        s_next.rst_drv   = s_reg.cl_sync[1] | s_reg.sl_sync[1];
        s_next.ms_cnt    = ms_tick ? 17'h00000 : s_reg.ms_cnt + 17'h00001;
        s_next.wait_cnt  = s_reg.wait_cnt + 12'h001;
        case (s_reg.st)
            ST_INIT: begin
                // first moment: operating mode and output polarity
                if (s_reg.wait_cnt == STRAP_GAP_CYC - 12'h001) begin
                    s_next.wait_cnt   = 12'h000;
                    s_next.standalone = s_reg.mode_sync[1];
                    s_next.active_low = !s_reg.pol_sync[1];
                    s_next.st         = ST_STRAP;
                end
            end
            ST_STRAP: begin
                // second moment: base frequency
                if (s_reg.wait_cnt == STRAP_GAP_CYC - 12'h001) begin
                    s_next.wait_cnt = 12'h000;
                    s_next.rate_60  = s_reg.pol_sync[1];
                    s_next.st       = fault_s ? ST_FAULT : ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_s) begin
                    s_next.st = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (!fault_s) begin
                    s_next.st        = ST_RETRY;
                    s_next.retry_cnt = 24'h000000;
                end
            end
            ST_RETRY: begin
                // a fault during the wait restarts the whole interval
                if (fault_s) begin
                    s_next.st = ST_FAULT;
                end else if (s_reg.retry_cnt >= retry_eff) begin
                    s_next.st = ST_RUN;
                end else if (ms_tick) begin
                    s_next.retry_cnt = s_reg.retry_cnt + 24'h000001;
                end
            end
            default: s_next.st = ST_INIT;
        endcase

        // reset pin low: back to start, straps resampled on release
        if (!s_reg.rp_sync[1]) begin
            s_next.st       = ST_INIT;
            s_next.wait_cnt = 12'h000;
        end

        // per phase: both off, then dead time, then the wanted side on
        for (int i = 0; i < 3; i++) begin
            want_top = gate_demand.top[i] & !gate_demand.bot[i];
            want_bot = gate_demand.bot[i] & !gate_demand.top[i];
            if (s_next.st != ST_RUN) begin
                s_next.cur_top[i] = 1'b0;
                s_next.cur_bot[i] = 1'b0;
                s_next.dt_cnt[i]  = dt_eff;
            end else if ((s_reg.cur_top[i] & !want_top) | (s_reg.cur_bot[i] & !want_bot)) begin
                s_next.cur_top[i] = 1'b0;
                s_next.cur_bot[i] = 1'b0;
                s_next.dt_cnt[i]  = dt_eff;
            end else if (s_reg.dt_cnt[i] != 12'h000) begin
                s_next.dt_cnt[i] = s_reg.dt_cnt[i] - 12'h001;
            end else begin
                s_next.cur_top[i] = want_top;
                s_next.cur_bot[i] = want_bot;
            end
        end

        // polarity applied last so an off phase always shows its inactive level
        s_next.drive.top = s_next.cur_top ^ {3{s_next.active_low}};
        s_next.drive.bot = s_next.cur_bot ^ {3{s_next.active_low}};
        s_next.drv_oe_n  = (s_next.st == ST_INIT) || (s_next.st == ST_STRAP);

        // strobes only exist in standalone mode once running
        s_next.rate_oe_n  = !(s_reg.standalone && s_next.st != ST_INIT
                              && s_next.st != ST_STRAP && mux_rate_read);
        s_next.boost_oe_n = !(s_reg.standalone && s_next.st != ST_INIT
                              && s_next.st != ST_STRAP && mux_boost_read);
    end

    // register the state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg            <= '0;
            s_reg.st         <= ST_INIT;
            s_reg.drv_oe_n   <= 1'b1;
            s_reg.rate_oe_n  <= 1'b1;
            s_reg.boost_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // host link receiver, listening only in host mode
    mpwm_uart_rx #(
        .BIT_CYC (BIT_CYC)
    ) u_rx (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .enable       (!s_reg.standalone && s_reg.st != ST_INIT),
        .rx_pin       (carrier_rate_strobe_serial_in),
        .rx_data      (rx_data),
        .rx_valid     (rx_valid),
        .rx_frame_err (rx_frame_err)
    );

    // reset and strobe pins are only ever pulled low; enables decide when
    assign reset_pin_out            = 1'b0;
    assign reset_pin_oe_n           = !s_reg.rst_drv;
    assign carrier_rate_strobe_out  = 1'b0;
    assign carrier_rate_strobe_oe_n = s_reg.rate_oe_n;
    assign boost_strobe_out         = 1'b0;
    assign boost_strobe_oe_n        = s_reg.boost_oe_n;
    assign phase_u_high_drive       = s_reg.drive.top[0];
    assign phase_v_high_drive       = s_reg.drive.top[1];
    assign phase_w_high_drive       = s_reg.drive.top[2];
    assign phase_u_low_drive        = s_reg.drive.bot[0];
    assign phase_v_low_drive        = s_reg.drive.bot[1];
    assign phase_w_low_drive        = s_reg.drive.bot[2];
    assign pwm_oe_n                 = s_reg.drv_oe_n;
    assign standalone_mode          = s_reg.standalone;
    assign pwm_active_low           = s_reg.active_low;
    assign base_rate_60hz           = s_reg.rate_60;
    assign fault_active             = (s_reg.st == ST_FAULT) || (s_reg.st == ST_RETRY);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_fault_released;
        s_reg.st == ST_FAULT && !fault_s && s_reg.rp_sync[1];
    endsequence
    sequence s_drives_off;
        s_reg.drive == {6{s_reg.active_low}};
    endsequence

    a_pin_reset_float: assert property (!s_reg.rp_sync[1] |=> s_reg.drv_oe_n)
        else $error("outputs driven while reset pin low");
    a_reset_pin_pull: assert property (
        (s_reg.cl_sync[1] || s_reg.sl_sync[1]) |=> !reset_pin_oe_n && !reset_pin_out)
        else $error("reset pin not pulled low on internal reset");
    a_fault_kills_drive: assert property (fault_s |=> s_drives_off)
        else $error("drive active during fault");
    a_retry_entry: assert property (s_fault_released |=> s_reg.st == ST_RETRY)
        else $error("retry not started on fault release");
    a_retry_quiet: assert property (s_reg.st == ST_RETRY |-> s_drives_off)
        else $error("drive active during retry");
    a_strap_base_rate: assert property (
        (s_reg.st == ST_STRAP && s_reg.wait_cnt == STRAP_GAP_CYC - 12'h001 && s_reg.rp_sync[1])
        |=> s_reg.rate_60 == $past(s_reg.pol_sync[1]))
        else $error("base rate not taken from strap");
    a_no_shoot_through: assert property ((s_reg.cur_top & s_reg.cur_bot) == 3'h0)
        else $error("top and bottom on together");
    a_rate_strobe_low: assert property (
        (s_reg.standalone && s_reg.st == ST_RUN && mux_rate_read && s_reg.rp_sync[1])
        |=> !carrier_rate_strobe_oe_n)
        else $error("rate strobe not driven during read");
    a_host_pin_input: assert property (!s_reg.standalone |-> carrier_rate_strobe_oe_n)
        else $error("serial pin driven in host mode");
    a_dead_gap: assert property (
        (s_reg.standalone && $fell(s_reg.cur_bot[0])) |-> !s_reg.cur_top[0] [*8])
        else $error("dead time shorter than minimum");
    a_retry_capped: assert property (s_reg.standalone |-> retry_eff <= RETRY_SA_MAX_MS)
        else $error("retry time over standalone limit");
    a_mode_sampled: assert property (
        (s_reg.st == ST_INIT && s_reg.wait_cnt == STRAP_GAP_CYC - 12'h001 && s_reg.rp_sync[1])
        |=> s_reg.standalone == $past(s_reg.mode_sync[1]))
        else $error("mode not taken from strap");
endmodule

/* File: mpwm_host_link.sv */
// host-side serial sender model driving the dual-use rate strobe pin
module mpwm_host_link #(
    parameter int BIT_CYC = 16
) (
    // clock
    input  wire logic sys_clk,
    // serial line towards the device
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;

    // the line rests high between frames, as a real host transmitter does
    initial line = 1'b1;

    // one 8n1 frame, lsb first, one bit every BIT_CYC clocks
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            line = frame[i];
            repeat (BIT_CYC - 1) @(negedge sys_clk);
        end
    endtask
endmodule

/* File: test_motor_pwm_fault_reset_pins.sv */
// self-checking bench for the pwm pin-control block
module test_motor_pwm_fault_reset_pins;
    timeunit 1ns;
    timeprecision 1ps;
    import mpwm_pkg::*;

    localparam int MS_C  = 100;
    localparam int BIT_C = 16;

    logic        sys_clk, rst, rst_pin_ext, clock_loss, supply_low, fault_input;
    logic        pol_strap, mode_level, mux_rate_read, mux_boost_read;
    mpwm_gate_s  gate_demand;
    logic [11:0] dead_time_cycles;
    logic [23:0] retry_ms;
    logic        reset_pin_in, reset_pin_out, reset_pin_oe_n, boost_pin, boost_out, boost_oe_n;
    logic        serial_pin, link_line, rate_out, rate_oe_n, pwm_oe_n;
    logic        u_h, u_l, v_h, v_l, w_h, w_l, standalone_mode, pwm_active_low, base_rate_60hz;
    logic        fault_active, rx_valid, rx_frame_err;
    logic [7:0]  rx_data;
    logic [5:0]  drv;
    int          failures, cmp_count;

    // wire levels: a pin pulled low by the device wins over the outside driver
    assign reset_pin_in = reset_pin_oe_n ? rst_pin_ext : reset_pin_out;
    assign boost_pin    = boost_oe_n ? mode_level : boost_out;
    assign serial_pin   = rate_oe_n ? link_line : rate_out;
    assign drv          = {u_h, u_l, v_h, v_l, w_h, w_l};

    mpwm_host_link #(.BIT_CYC(BIT_C)) link (.sys_clk(sys_clk), .line(link_line));

    mpwm_pin_ctrl #(.MS_CYC(MS_C), .BIT_CYC(BIT_C)) dut (
        .sys_clk(sys_clk), .rst(rst), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
        .clock_loss(clock_loss), .supply_low(supply_low), .fault_input(fault_input),
        .polarity_base_rate_strap(pol_strap), .boost_strobe_mode_strap(boost_pin),
        .boost_strobe_out(boost_out), .boost_strobe_oe_n(boost_oe_n),
        .carrier_rate_strobe_serial_in(serial_pin), .carrier_rate_strobe_out(rate_out),
        .carrier_rate_strobe_oe_n(rate_oe_n), .gate_demand(gate_demand),
        .dead_time_cycles(dead_time_cycles), .retry_ms(retry_ms),
        .mux_rate_read(mux_rate_read), .mux_boost_read(mux_boost_read),
        .phase_u_high_drive(u_h), .phase_u_low_drive(u_l), .phase_v_high_drive(v_h),
        .phase_v_low_drive(v_l), .phase_w_high_drive(w_h), .phase_w_low_drive(w_l),
        .pwm_oe_n(pwm_oe_n), .standalone_mode(standalone_mode),
        .pwm_active_low(pwm_active_low), .base_rate_60hz(base_rate_60hz),
        .fault_active(fault_active), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_frame_err(rx_frame_err));

    // 100 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // compare with case equality so an unknown never passes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // reset, then move the strap between the two sampling moments
    task automatic do_init(input logic mode, input logic rate60);
        rst = 1'b1;
        mode_level = mode;
        // first moment sees the inverse, so both polarities get exercised
        pol_strap = !rate60;
        cyc(12);
        chk(pwm_oe_n, 1'b1);
        chk(drv, 6'h00);
        rst = 1'b0;
        cyc(1500);
        pol_strap = rate60;
        cyc(700);
    endtask

    // hang guard well beyond the expected 4950 or so cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_sim();
    end

    // main sequence
    initial begin
        failures = 0;
        cmp_count = 0;
        {rst, rst_pin_ext, clock_loss, supply_low, fault_input} = 5'b11000;
        {pol_strap, mode_level, mux_rate_read, mux_boost_read} = 4'b1100;
        gate_demand = '{top: 3'b000, bot: 3'b000};
        dead_time_cycles = 12'h00A;
        retry_ms = 24'h000002;
        do_init(1'b1, 1'b0);
        chk(standalone_mode, 1'b1);
        chk(pwm_active_low, 1'b0);
        chk(base_rate_60hz, 1'b0);
        chk(pwm_oe_n, 1'b0);
        // six drives, u first, then all top sides
        gate_demand = '{top: 3'b001, bot: 3'b000};
        cyc(2);
        chk(drv, 6'h20);
        gate_demand = '{top: 3'b111, bot: 3'b000};
        cyc(2);
        chk(drv, 6'h2A);
        // a 10-cycle dead time is raised to the 50-cycle floor
        gate_demand = '{top: 3'b000, bot: 3'b111};
        cyc(30);
        chk(drv, 6'h00);
        cyc(30);
        chk(drv, 6'h15);
        // fault cuts drives at once; retry of 2 ms ticks keeps them off
        fault_input = 1'b1;
        cyc(3);
        chk(drv, 6'h00);
        chk(fault_active, 1'b1);
        cyc(20);
        fault_input = 1'b0;
        cyc(90);
        chk(drv, 6'h00);
        cyc(150);
        chk(drv, 6'h15);
        chk(fault_active, 1'b0);
        // standalone strobes pull their pins low while the mux is read
        {mux_rate_read, mux_boost_read} = 2'b11;
        cyc(2);
        chk(rate_oe_n, 1'b0);
        chk(serial_pin, 1'b0);
        chk(boost_oe_n, 1'b0);
        chk(boost_pin, 1'b0);
        {mux_rate_read, mux_boost_read} = 2'b00;
        cyc(2);
        chk(rate_oe_n, 1'b1);
        // each internal reset source pulls the pin and so resets the block
        for (int i = 0; i < 2; i++) begin
            {supply_low, clock_loss} = 2'(1 << i);
            cyc(4);
            chk(reset_pin_oe_n, 1'b0);
            cyc(4);
            chk(pwm_oe_n, 1'b1);
            {supply_low, clock_loss} = 2'b00;
            cyc(4);
            chk(reset_pin_oe_n, 1'b1);
        end
        // host mode: strobe pin stays an input and carries serial bytes
        do_init(1'b0, 1'b1);
        chk(standalone_mode, 1'b0);
        chk(pwm_active_low, 1'b1);
        chk(base_rate_60hz, 1'b1);
        mux_rate_read = 1'b1;
        cyc(2);
        chk(rate_oe_n, 1'b1);
        mux_rate_read = 1'b0;
        fork
            link.send_byte(8'hA5);
            begin
                // rx_valid stands one cycle, mid stop bit, before the sender returns
                for (int k = 0; k < 200; k++) begin
                    @(negedge sys_clk);
                    if (rx_valid === 1'b1)
                        break;
                end
                chk(rx_valid, 1'b1);
            end
        join
        chk(rx_data, 8'hA5);
        chk(rx_frame_err, 1'b0);
        // an outside low on the reset pin floats drives that are running
        chk(pwm_oe_n, 1'b0);
        chk(drv, 6'h2A);
        rst_pin_ext = 1'b0;
        cyc(6);
        chk(pwm_oe_n, 1'b1);
        chk(drv, 6'h3F);
        rst_pin_ext = 1'b1;
        end_sim();
    end
endmodule
